// ### verilog/fsw_pkg.sv
`default_nettype none
// ==========================================================
// Feed sequence watchdog constants and types
package fsw_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [31:0] FSW_MODE_ADDR = 32'he000_0000;
  localparam logic [31:0] FSW_RELOAD_ADDR = 32'he000_0004;
  localparam logic [31:0] FSW_FEED_ADDR = 32'he000_0008;
  localparam logic [31:0] FSW_VALUE_ADDR = 32'he000_000c;

  // ==========================================================
  // Mode register field positions
  localparam int FSW_EN_BIT = 0;
  localparam int FSW_RSTEN_BIT = 1;
  localparam int FSW_TOF_BIT = 2;
  localparam int FSW_INT_BIT = 3;

  // ==========================================================
  // Reset values and feed bytes
  localparam logic [31:0] FSW_RELOAD_RST = 32'h0000_00ff;
  localparam logic [31:0] FSW_RELOAD_MIN = 32'h0000_00ff;
  localparam logic [31:0] FSW_VALUE_RST = 32'h0000_00ff;
  localparam logic [7:0] FSW_FEED_FIRST = 8'h0aa;
  localparam logic [7:0] FSW_FEED_SECOND = 8'h055;

  // ==========================================================
  // Timing
  localparam int FSW_CLK_MHZ = 100;
  localparam int FSW_PRESCALE_DIV = 4;
  localparam logic [1:0] FSW_PRESCALE_LAST = 2'(FSW_PRESCALE_DIV - 1);

  // ==========================================================
  // Types
  typedef struct packed {
    logic [3:0] reserved;
    logic underflowIntFlag;
    logic timeoutOccurredFlag;
    logic chipResetEnable;
    logic watchdogEnable;
  } fsw_mode_t;

  localparam fsw_mode_t FSW_MODE_RST = '{default: 1'b0};

  typedef enum logic [0:0] {
    FSW_FEED_IDLE = 1'b0,
    FSW_FEED_ARMED = 1'b1
  } fsw_feed_state_t;

endpackage : fsw_pkg
`default_nettype wire

// ### verilog/fsw_feed_watchdog.sv
// Summary of operation
// [RULE1] Time-out flag clears only on external reset; watchdog reset leaves it set. The code also clears it on a mode write with bit 2 low.
// [RULE2] Interrupt flag is read-only; writes to its bit do nothing.
// [RULE3] Software writes no ones to mode bits 7:4; they read as zero.
// [RULE4] Each valid feed loads the reload constant into the down-counter. The code ignores a feed that lands in the same cycle as a trigger.
// [RULE5] Reload constant is 32-bit read/write, resets to 0xFF.
// [RULE6] Writes below 0xFF store 0xFF instead.
// [RULE7] Minimum interval is 256 steps of four clock periods.
// [RULE8] Valid feed is 0xAA then 0x55 written to the feed port.
// [RULE9] Enable alone does not start; a valid feed with enable set starts.
// [RULE10] Feed errors are ignored until the watchdog has started.
// [RULE11] After 0xAA, any access other than a 0x55 feed write triggers.
// [RULE12] Broken feed acts in the second clock cycle after the access.
// [RULE13] Value register returns full 32-bit count, resets to 0xFF.
// [RULE14] Disabled: no count; interrupt mode sets flag; reset mode resets chip.
// [RULE15] Enable bits are set-only; cleared by external reset or underflow. The code also clears them on a broken feed.
// [RULE16] Counter decrements once every four clock cycles.
// [RULE17] Time-out flag sets on every time-out and stays until cleared.
// [RULE18] Interrupt output follows the flag; any reset clears it.
`timescale 1ns/10ps
`default_nettype none

module fsw_feed_watchdog
  import fsw_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wdIrq,
  output logic wdChipReset
);

  // ==========================================================
  // Functions
  function automatic logic [31:0] clampReload(input logic [31:0] val);
    clampReload = (val < FSW_RELOAD_MIN) ? FSW_RELOAD_MIN : val;
  endfunction

  // Full 32-bit compare, so aliases of the registers are refused
  function automatic logic addrHit(input logic [31:0] addr, input logic [31:0] target);
    addrHit = (addr == target);
  endfunction

  // ==========================================================
  // State
  fsw_mode_t mode_r;
  fsw_mode_t mode_nxt;
  logic [31:0] reload_r;
  logic [31:0] reload_nxt;
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic [1:0] prescale_r;
  logic [1:0] prescale_nxt;
  logic running_r;
  logic running_nxt;
  logic brokenFeed_r;
  fsw_feed_state_t feedState_r;
  fsw_feed_state_t feedState_nxt;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic chipReset_r;

  // ==========================================================
  // Bus decode
  wire logic accessPhase = psel & penable;
  wire logic respond = accessPhase & ~pready_r;
  wire logic done = accessPhase & pready_r;
  wire logic hitMode = addrHit(paddr, FSW_MODE_ADDR);
  wire logic hitReload = addrHit(paddr, FSW_RELOAD_ADDR);
  wire logic hitFeed = addrHit(paddr, FSW_FEED_ADDR);
  wire logic hitValue = addrHit(paddr, FSW_VALUE_ADDR);
  wire logic hitAny = hitMode | hitReload | hitFeed | hitValue;
  wire logic wrMode = done & pwrite & hitMode;
  wire logic wrReload = done & pwrite & hitReload;
  wire logic wrFeed = done & pwrite & hitFeed;
  wire logic [7:0] feedByte = pwdata[7:0];

  // Unmapped addresses and writes to the value register are refused
  wire logic badAccess = ~hitAny | (pwrite & hitValue);

  wire logic [31:0] readMux =
    hitMode ? {24'h00_0000, 4'h0, mode_r.underflowIntFlag, mode_r.timeoutOccurredFlag,
               mode_r.chipResetEnable, mode_r.watchdogEnable} : // [RULE3]
    hitReload ? reload_r :
    hitValue ? count_r : // [RULE13]
    32'h0000_0000;

  // ==========================================================
  // Feed sequence
  wire logic feedFirst = wrFeed & (feedByte == FSW_FEED_FIRST);
  wire logic feedSecond = wrFeed & (feedByte == FSW_FEED_SECOND);
  wire logic armed = (feedState_r == FSW_FEED_ARMED);
  wire logic validFeed = armed & feedSecond; // [RULE8]
  // Any completed access in the space other than a 0x55 feed write breaks an armed sequence
  wire logic brokenAccess = armed & done & ~feedSecond; // [RULE11]

  always_comb begin
    feedState_nxt = feedState_r;
    unique case (feedState_r)
      FSW_FEED_IDLE: begin
        if (feedFirst) begin
          feedState_nxt = FSW_FEED_ARMED; // [RULE8]
        end
      end
      FSW_FEED_ARMED: begin
        if (done) begin
          feedState_nxt = FSW_FEED_IDLE;
        end
      end
    endcase
  end

  // ==========================================================
  // Counter and trigger
  wire logic tick = (prescale_r == FSW_PRESCALE_LAST); // [RULE16]
  wire logic countActive = running_r & mode_r.watchdogEnable; // [RULE14]
  wire logic underflow = countActive & tick & (count_r == 32'h0000_0000);
  // Error was registered one edge earlier, so action lands in cycle two
  wire logic trigger = underflow | brokenFeed_r; // [RULE12]
  wire logic chip_reset_enable_bit = trigger & mode_r.chipResetEnable; // [RULE14]
  wire logic wdInterrupt = trigger & ~mode_r.chipResetEnable;

  always_comb begin
    prescale_nxt = prescale_r + 2'd1;
    count_nxt = count_r;
    running_nxt = running_r;
    if (countActive & tick) begin
      count_nxt = count_r - 32'h0000_0001; // [RULE16]
    end
    if (validFeed) begin
      count_nxt = reload_r; // [RULE4] [RULE7]
      prescale_nxt = 2'd0;
      if (mode_r.watchdogEnable) begin
        running_nxt = 1'b1; // [RULE9]
      end
    end
    if (trigger) begin
      running_nxt = 1'b0;
      count_nxt = count_r;
    end
    if (chip_reset_enable_bit) begin
      count_nxt = FSW_VALUE_RST;
      prescale_nxt = 2'd0;
    end
  end

  // ==========================================================
  // Mode and reload registers
  always_comb begin
    mode_nxt = mode_r;
    reload_nxt = reload_r;
    mode_nxt.reserved = 4'h0;
    if (wrMode) begin
      mode_nxt.watchdogEnable = mode_r.watchdogEnable | pwdata[FSW_EN_BIT]; // [RULE15]
      mode_nxt.chipResetEnable = mode_r.chipResetEnable | pwdata[FSW_RSTEN_BIT]; // [RULE15]
      if (!pwdata[FSW_TOF_BIT]) begin
        mode_nxt.timeoutOccurredFlag = 1'b0; // [RULE17]
      end
      // Interrupt flag bit of the write is ignored [RULE2]
    end
    if (wrReload) begin
      reload_nxt = clampReload(pwdata); // [RULE6]
    end
    if (trigger) begin
      // Set wins over a clear in the same cycle
      mode_nxt.timeoutOccurredFlag = 1'b1; // [RULE17] [RULE1]
      mode_nxt.watchdogEnable = 1'b0; // [RULE15]
      mode_nxt.chipResetEnable = 1'b0; // [RULE15]
    end
    if (wdInterrupt) begin
      mode_nxt.underflowIntFlag = 1'b1; // [RULE14]
    end
    if (chip_reset_enable_bit) begin
      // Chip reset clears all but the time-out flag
      mode_nxt.underflowIntFlag = 1'b0; // [RULE18]
      reload_nxt = FSW_RELOAD_RST;
    end
  end

  // ==========================================================
  // Next values of the bus response and trigger flops
  wire logic brokenFeed_nxt = brokenAccess & running_r & ~trigger; // [RULE10] [RULE12]
  // One wait state: answer comes in the second access cycle
  wire logic pready_nxt = respond;
  wire logic pslverr_nxt = respond & badAccess;
  wire logic [31:0] prdata_nxt = (respond & ~pwrite) ? readMux : 32'h0000_0000;
  wire logic chipReset_nxt = chip_reset_enable_bit; // [RULE14]
  // Watchdog reset restarts the counter side; mode keeps only the time-out flag and reload returns to 0xFF
  wire logic counterClear = sys_rst | chip_reset_enable_bit;

  // ==========================================================
  // Registers reset only by sys_rst; a watchdog reset acts through their next values
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_r <= FSW_MODE_RST; // [RULE1]
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reload_r <= FSW_RELOAD_RST; // [RULE5]
    end else begin
      reload_r <= reload_nxt;
    end
  end

  // ==========================================================
  // Counter side registers
  always_ff @(posedge clock) begin
    if (counterClear) begin
      count_r <= FSW_VALUE_RST; // [RULE13]
    end else begin
      count_r <= count_nxt;
    end
  end

  // Restarts on a feed so the first step is four full clocks
  always_ff @(posedge clock) begin
    if (counterClear) begin
      prescale_r <= 2'd0;
    end else begin
      prescale_r <= prescale_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (counterClear) begin
      running_r <= 1'b0;
    end else begin
      running_r <= running_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (counterClear) begin
      feedState_r <= FSW_FEED_IDLE;
    end else begin
      feedState_r <= feedState_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (counterClear) begin
      brokenFeed_r <= 1'b0;
    end else begin
      brokenFeed_r <= brokenFeed_nxt;
    end
  end

  // ==========================================================
  // Bus response registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= pslverr_nxt;
    end
  end

  // Zero outside the answer cycle, so stale data never shows
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata_r <= 32'h0000_0000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // One cycle only: the trigger clears reset-enable at once
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      chipReset_r <= 1'b0;
    end else begin
      chipReset_r <= chipReset_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign wdIrq = mode_r.underflowIntFlag; // [RULE18]
  assign wdChipReset = chipReset_r;

endmodule // fsw_feed_watchdog
`default_nettype wire

// ### tb/fsw_chk_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Port checker
module fsw_chk
  import fsw_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wdIrq,
  input wire logic wdChipReset
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire logic rdOk = pready && !pwrite;
  property p_ans; psel && $rose(penable) |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("ready late");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held");
  property p_pls; wdChipReset |=> !wdChipReset; endproperty
  a_pls: assert property (p_pls) else $error("reset pulse long");
  property p_irq; wdIrq |=> wdIrq || wdChipReset; endproperty
  a_irq: assert property (p_irq) else $error("irq dropped");
  property p_rst; $past(sys_rst) |-> !wdIrq && !wdChipReset; endproperty
  a_rst: assert property (p_rst) else $error("out after reset");
  property p_ro; pready && pwrite && paddr == FSW_VALUE_ADDR |-> pslverr; endproperty
  a_ro: assert property (p_ro) else $error("value write taken");
  property p_rsv; rdOk && paddr == FSW_MODE_ADDR |-> prdata[31:4] == '0; endproperty
  a_rsv: assert property (p_rsv) else $error("mode upper bits");
  property p_min; rdOk && paddr == FSW_RELOAD_ADDR |-> prdata >= FSW_RELOAD_MIN; endproperty
  a_min: assert property (p_min) else $error("reload below min");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  c_irq: cover property ($rose(wdIrq));
  c_crst: cover property (wdChipReset);
  c_err: cover property (pready && pslverr);
endmodule // fsw_chk
bind fsw_feed_watchdog fsw_chk chk_u (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .wdIrq, .wdChipReset);
`default_nettype wire

// ### tb/fsw_sw_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Software side bus master
module fsw_sw_model (
  input wire logic clock,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic busHung
);
  initial begin
    {psel, penable, pwrite, busHung} = '0;
    {paddr, pwdata} = '0;
  end
  // Idle address and data are poisoned so nothing leans on stale values
  task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r,
      output logic e);
    int n;
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge clock);
    busHung |= (n == 16);
    r = prdata;
    e = pslverr;
    {psel, penable} <= '0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // fsw_sw_model
`default_nettype wire

// ### tb/fsw_feed_watchdog_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Watchdog bench
module fsw_feed_watchdog_tb_top
  import fsw_pkg::*;
;
  logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, wdIrq, wdChipReset, busHung;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic er;
  int miscompares, checked, n;
  fsw_feed_watchdog dut_u (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .wdIrq, .wdChipReset);
  fsw_sw_model bus_u (.clock, .prdata, .pready, .pslverr, .psel, .penable, .pwrite,
    .paddr, .pwdata, .busHung);
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    bus_u.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic rdv(input logic [31:0] a);
    bus_u.xfer(1'b0, a, '0, rd, er);
  endtask
  task automatic feed();
    wr(FSW_FEED_ADDR, 32'(FSW_FEED_FIRST));
    wr(FSW_FEED_ADDR, 32'(FSW_FEED_SECOND));
  endtask
  task automatic rst();
    @(posedge clock);
    sys_rst <= 1;
    repeat (5) @(posedge clock);
    sys_rst <= 0;
  endtask
  task automatic t_regs();
    rdv(FSW_MODE_ADDR);
    chk(rd, '0);
    rdv(FSW_VALUE_ADDR);
    chk(rd, FSW_VALUE_RST);
    rdv(FSW_RELOAD_ADDR);
    chk(rd, FSW_RELOAD_RST);
    wr(FSW_RELOAD_ADDR, 32'h0001_2345);
    rdv(FSW_RELOAD_ADDR);
    chk(rd, 32'h0001_2345);
    feed();
    repeat (40) @(posedge clock);
    rdv(FSW_VALUE_ADDR);
    chk(rd, 32'h0001_2345);
    rdv(FSW_FEED_ADDR);
    chk(rd, '0);
    wr(FSW_RELOAD_ADDR, 32'h0000_0010);
    rdv(FSW_RELOAD_ADDR);
    chk(rd, FSW_RELOAD_MIN);
    wr(FSW_VALUE_ADDR, '0);
    chk(32'(er), 32'h0000_0001);
    wr(FSW_MODE_ADDR, 32'h0000_0008);
    rdv(FSW_MODE_ADDR);
    chk(rd, '0);
    wr(FSW_FEED_ADDR, 32'(FSW_FEED_FIRST));
    rdv(32'h0000_0100);
    repeat (4) @(posedge clock);
    chk(32'({wdIrq, wdChipReset}), '0);
    $display("regs test done");
  endtask
  task automatic t_irq();
    wr(FSW_MODE_ADDR, 32'h0000_0001);
    wr(FSW_MODE_ADDR, '0);
    rdv(FSW_MODE_ADDR);
    chk(rd, 32'h0000_0001);
    repeat (12) @(posedge clock);
    rdv(FSW_VALUE_ADDR);
    chk(rd, 32'h0001_2345);
    feed();
    for (n = 0; n < 1100 && wdIrq !== 1'b1; n++) @(posedge clock);
    chk(32'(n >= 1022 && n <= 1028), 32'h0000_0001);
    rdv(FSW_MODE_ADDR);
    chk(rd, 32'h0000_000c);
    wr(FSW_MODE_ADDR, '0);
    rdv(FSW_MODE_ADDR);
    chk(rd, 32'h0000_0008);
    rst();
    chk(32'(wdIrq), '0);
    $display("irq test done");
  endtask
  task automatic t_break();
    wr(FSW_RELOAD_ADDR, 32'h0000_0300);
    wr(FSW_MODE_ADDR, 32'h0000_0003);
    feed();
    rdv(FSW_VALUE_ADDR);
    chk(32'(rd <= 32'h0000_0300 && rd >= 32'h0000_02f0), 32'h0000_0001);
    wr(FSW_FEED_ADDR, 32'(FSW_FEED_FIRST));
    rdv(FSW_RELOAD_ADDR);
    for (n = 0; n < 6 && wdChipReset !== 1'b1; n++) @(posedge clock);
    chk(32'(n >= 2 && n <= 3), 32'h0000_0001);
    rdv(FSW_MODE_ADDR);
    chk(rd, 32'h0000_0004);
    rst();
    rdv(FSW_MODE_ADDR);
    chk(rd, '0);
    $display("break test done");
  endtask
  task automatic complete_run();
    if (busHung) miscompares++;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    sys_rst = 1;
    rst();
    t_regs();
    t_irq();
    t_break();
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge clock);
    miscompares++;
    complete_run();
  end
endmodule // fsw_feed_watchdog_tb_top
`default_nettype wire
